// ===== rtl/chgrb_pkg.sv
`default_nettype none
package chgrb_pkg;

   // timing base
   localparam int CLK_HZ       = 100_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int WDT_TICK_NS  = 1_000_000;
   localparam int WDT_TICK_CYCLES = WDT_TICK_NS / CLK_PERIOD_NS;
   localparam int WDT_SHORT_S  = 5;
   localparam int WDT_MID_S    = 88;
   localparam int WDT_LONG_S   = 175;
   localparam int MS_PER_S     = 1_000;
   localparam int WDT_SHORT_TICKS = WDT_SHORT_S * MS_PER_S;
   localparam int WDT_MID_TICKS   = WDT_MID_S * MS_PER_S;
   localparam int WDT_LONG_TICKS  = WDT_LONG_S * MS_PER_S;
   localparam int WDT_CNT_W    = 18;

   // bus framing
   localparam logic [6:0] SLAVE_ADDR = 7'h09;
   localparam logic [3:0] BIT_LAST   = 4'h7;
   localparam logic [3:0] BIT_ACK    = 4'h8;

   // command codes
   localparam logic [7:0] CMD_OPT_A  = 8'h12;
   localparam logic [7:0] CMD_CUR    = 8'h14;
   localparam logic [7:0] CMD_VOLT   = 8'h15;
   localparam logic [7:0] CMD_OPT_D  = 8'h37;
   localparam logic [7:0] CMD_OPT_C  = 8'h38;
   localparam logic [7:0] CMD_DIS    = 8'h39;
   localparam logic [7:0] CMD_TSTAT  = 8'h3A;
   localparam logic [7:0] CMD_OPT_B  = 8'h3B;
   localparam logic [7:0] CMD_TOPT_A = 8'h3C;
   localparam logic [7:0] CMD_TOPT_B = 8'h3D;
   localparam logic [7:0] CMD_ILIM   = 8'h3F;
   localparam logic [7:0] CMD_MAKER  = 8'hFE;
   localparam logic [7:0] CMD_PART   = 8'hFF;

   // register indices; storage holds indices below NUM_STORE
   localparam int NUM_CMDS  = 13;
   localparam int NUM_STORE = 11;
   localparam logic [3:0] IDX_OPT_A  = 4'h0;
   localparam logic [3:0] IDX_CUR    = 4'h1;
   localparam logic [3:0] IDX_VOLT   = 4'h2;
   localparam logic [3:0] IDX_OPT_D  = 4'h3;
   localparam logic [3:0] IDX_OPT_C  = 4'h4;
   localparam logic [3:0] IDX_DIS    = 4'h5;
   localparam logic [3:0] IDX_TSTAT  = 4'h6;
   localparam logic [3:0] IDX_OPT_B  = 4'h7;
   localparam logic [3:0] IDX_TOPT_A = 4'h8;
   localparam logic [3:0] IDX_TOPT_B = 4'h9;
   localparam logic [3:0] IDX_ILIM   = 4'hA;
   localparam logic [3:0] IDX_MAKER  = 4'hB;
   localparam logic [3:0] IDX_PART   = 4'hC;

   typedef logic [15:0] chgrb_word_t;

   localparam chgrb_word_t RST_VAL [NUM_STORE] = '{
      16'hE108, 16'h0000, 16'h0000, 16'h1A40, 16'h0384, 16'h1800,
      16'h0000, 16'hC210, 16'h4A54, 16'h8120, 16'h1000};
   localparam chgrb_word_t WR_MASK [NUM_STORE] = '{
      16'hE339, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'h0000, 16'hFEFA, 16'hFFFF, 16'hFFFF, 16'hFFFF};

   // identity words, values arbitrary
   localparam chgrb_word_t MAKER_ID_DEF = 16'h005A;
   localparam chgrb_word_t PART_ID_DEF  = 16'h00A5;

   // option A field positions
   localparam int OPA_LOWPWR  = 15;
   localparam int OPA_WDT_HI  = 14;
   localparam int OPA_WDT_LO  = 13;
   localparam int OPA_FREQ_HI = 9;
   localparam int OPA_FREQ_LO = 8;
   localparam int OPA_BATTERY_MODE_A   = 5;
   localparam int OPA_ADPGAIN = 4;
   localparam int OPA_DISGAIN = 3;
   localparam int OPA_BLOCK   = 0;

   localparam logic [1:0] WDT_OFF    = 2'h0;
   localparam logic [1:0] WDT_SHORT  = 2'h1;
   localparam logic [1:0] WDT_MID    = 2'h2;
   localparam logic [1:0] FREQ_RSVD  = 2'h3;

   typedef struct packed {
      logic       low_power_select;
      logic [1:0] watchdog_period_select;
      logic [1:0] switching_rate_select;
      logic       battery_mode_a_enable;
      logic       adapter_monitor_gain;
      logic       discharge_monitor_gain;
      logic       charge_block;
   } chgrb_opt_t;

   typedef struct packed {
      chgrb_word_t charge_current_setting;
      chgrb_word_t charge_voltage_setting;
      chgrb_word_t discharge_current_limit;
      chgrb_word_t input_current_limit;
      chgrb_word_t charge_options_b;
      chgrb_word_t charge_options_c;
      chgrb_word_t charge_options_d;
      chgrb_word_t throttle_options_a;
      chgrb_word_t throttle_options_b;
   } chgrb_cfg_t;

   typedef struct packed {
      logic converter_enable;
      logic charge_enable;
      logic battery_mode_a;
      logic adapter_switch_on;
      logic reverse_block_switch_on;
      logic battery_switch_on;
      logic throttle_output_enable;
      logic monitor_buffer_enable;
      logic comparator_enable;
      logic switching_rate_valid;
   } chgrb_pwr_t;

endpackage
`default_nettype wire

// ===== rtl/chgrb_sync.sv
`timescale 1ns/10ps
`default_nettype none
module chgrb_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   // pins idle high on an open-drain bus, so reset to one
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
               meta_r[gi] <= 1'b1;
               hold_r[gi] <= 1'b1;
            end else begin
               meta_r[gi] <= async_i[gi];
               hold_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   assign sync_o = hold_r;
endmodule // chgrb_sync
`default_nettype wire

// ===== rtl/chgrb_wdog.sv
`timescale 1ns/10ps
`default_nettype none
module chgrb_wdog
   import chgrb_pkg::*;
#(
   parameter int TICK_CYCLES_P = WDT_TICK_CYCLES
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] period_sel_i,
   input  wire logic       kick_i,
   output logic            expired_o
);
   localparam int TW = $clog2(TICK_CYCLES_P + 1);

   logic [TW-1:0]        div_r,  div_nxt;
   logic [WDT_CNT_W-1:0] cnt_r,  cnt_nxt;
   logic                 exp_r,  exp_nxt;
   logic                 tick;
   logic [WDT_CNT_W-1:0] limit;

   always_comb begin
      case (period_sel_i)
         WDT_SHORT: limit = WDT_CNT_W'(WDT_SHORT_TICKS);
         WDT_MID:   limit = WDT_CNT_W'(WDT_MID_TICKS);
         default:   limit = WDT_CNT_W'(WDT_LONG_TICKS);
      endcase
   end

   assign tick = (div_r == TW'(TICK_CYCLES_P - 1));

   always_comb begin
      div_nxt = tick ? '0 : div_r + 1'b1;
      cnt_nxt = cnt_r;
      exp_nxt = exp_r;
      if (period_sel_i == WDT_OFF) begin
         div_nxt = '0;
         cnt_nxt = '0;
         exp_nxt = 1'b0;
      end else begin
         if (tick && cnt_r < limit) begin
            cnt_nxt = cnt_r + 1'b1;
         end
         if (kick_i) begin
            div_nxt = '0;
            cnt_nxt = '0;
            exp_nxt = 1'b0;
         end
         // expiry beats a write landing in the same cycle
         if (cnt_r >= limit && !exp_r) begin
            exp_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         div_r <= '0;
         cnt_r <= '0;
         exp_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign expired_o = exp_r;
endmodule // chgrb_wdog
`default_nettype wire

// ===== rtl/chgrb_bank.sv
// Functional notes
// - thirteen word registers, read or written by command
// - fixed maker and part words at FE, FF
// - option registers load their power-on values
// - current limits preset, charge settings reset zero
// - throttle status read-only, resets to zero
// - low-power bit disables throttle, monitors, comparator
// - watchdog field selects off, 5, 88, 175 s
// - no current/voltage write in period stops converter
// - next current/voltage write restarts watchdog, resumes
// - switching rate field: 600k, 800k, 1M, reserved
// - battery_mode_a mode: adapter switches off, battery on
// - battery removal in battery_mode_a clears battery_mode_a bit
// - depleted battery refuses battery_mode_a mode
// - bit 4 selects adapter monitor gain
// - bit 3 selects discharge monitor gain
// - bit 0 inhibits charging; zero permits it
// - slave only, answers 7-bit address 0x09
// - command, low byte, high byte; ninth-clock ack
`timescale 1ns/10ps
`default_nettype none
module chgrb_bank
   import chgrb_pkg::*;
#(
   parameter int          TICK_CYCLES_P = WDT_TICK_CYCLES,
   parameter chgrb_word_t MAKER_ID      = MAKER_ID_DEF,
   parameter chgrb_word_t PART_ID       = PART_ID_DEF
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        battery_present_n_i,
   input  wire logic        battery_depleted_i,
   input  wire chgrb_word_t throttle_status_i,
   output chgrb_opt_t       opt_o,
   output chgrb_cfg_t       cfg_o,
   output chgrb_pwr_t       pwr_o,
   output logic             watchdog_expired_o
);

   typedef enum {
      ST_IDLE,
      ST_START,
      ST_ADDR,
      ST_CMD,
      ST_DLO,
      ST_DHI,
      ST_TXLO,
      ST_TXHI,
      ST_SKIP
   } chgrb_st_t;

   // returns {hit, index}
   function automatic logic [4:0] cmd_decode(input logic [7:0] cmd);
      case (cmd)
         CMD_OPT_A:  cmd_decode = {1'b1, IDX_OPT_A};
         CMD_CUR:    cmd_decode = {1'b1, IDX_CUR};
         CMD_VOLT:   cmd_decode = {1'b1, IDX_VOLT};
         CMD_OPT_D:  cmd_decode = {1'b1, IDX_OPT_D};
         CMD_OPT_C:  cmd_decode = {1'b1, IDX_OPT_C};
         CMD_DIS:    cmd_decode = {1'b1, IDX_DIS};
         CMD_TSTAT:  cmd_decode = {1'b1, IDX_TSTAT};
         CMD_OPT_B:  cmd_decode = {1'b1, IDX_OPT_B};
         CMD_TOPT_A: cmd_decode = {1'b1, IDX_TOPT_A};
         CMD_TOPT_B: cmd_decode = {1'b1, IDX_TOPT_B};
         CMD_ILIM:   cmd_decode = {1'b1, IDX_ILIM};
         CMD_MAKER:  cmd_decode = {1'b1, IDX_MAKER};
         CMD_PART:   cmd_decode = {1'b1, IDX_PART};
         default:    cmd_decode = 5'h00;
      endcase
   endfunction

   // ---------------- pin synchronisers
   logic [3:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       bat_absent_s;
   logic       depleted_s;

   chgrb_sync #(
      .W (4)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    ({battery_depleted_i, battery_present_n_i, sda_i, scl_i}),
      .sync_o     (pins_s)
   );

   assign scl_s        = pins_s[0];
   assign sda_s        = pins_s[1];
   assign bat_absent_s = pins_s[2];
   assign depleted_s   = pins_s[3];

   // ---------------- bus slave
   chgrb_st_t   st_r,     st_nxt;
   logic [3:0]  bit_r,    bit_nxt;
   logic [7:0]  sh_r,     sh_nxt;
   logic [7:0]  cmd_r,    cmd_nxt;
   logic [7:0]  lo_r,     lo_nxt;
   logic [7:0]  txd_r,    txd_nxt;
   logic [7:0]  rdhi_r,   rdhi_nxt;
   logic        oe_r,     oe_nxt;
   logic        mack_r,   mack_nxt;
   logic        scl_d_r;
   logic        sda_d_r;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic        wr_stb;
   chgrb_word_t wr_data;
   logic [4:0]  acc_dec;
   chgrb_word_t rd_word;
   chgrb_word_t regs_r   [NUM_STORE];

   assign scl_rise  = scl_s & ~scl_d_r;
   assign scl_fall  = ~scl_s & scl_d_r;
   assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign wr_data   = {sh_r, lo_r};
   assign acc_dec   = cmd_decode(cmd_r);

   always_comb begin
      if (!acc_dec[4]) begin
         rd_word = '0;
      end else if (acc_dec[3:0] == IDX_MAKER) begin
         rd_word = MAKER_ID;
      end else if (acc_dec[3:0] == IDX_PART) begin
         rd_word = PART_ID;
      end else begin
         rd_word = regs_r[acc_dec[3:0]];
      end
   end

   always_comb begin
      st_nxt   = st_r;
      bit_nxt  = bit_r;
      sh_nxt   = sh_r;
      cmd_nxt  = cmd_r;
      lo_nxt   = lo_r;
      txd_nxt  = txd_r;
      rdhi_nxt = rdhi_r;
      oe_nxt   = oe_r;
      mack_nxt = mack_r;
      wr_stb   = 1'b0;
      if (stop_det) begin
         st_nxt = ST_IDLE;
         oe_nxt = 1'b0;
      end else if (start_det) begin
         st_nxt  = ST_START;
         bit_nxt = '0;
         oe_nxt  = 1'b0;
      end else begin
         case (st_r)
            ST_ADDR, ST_CMD, ST_DLO, ST_DHI: begin
               if (scl_rise && bit_r < BIT_ACK) begin
                  sh_nxt = {sh_r[6:0], sda_s};
               end
               if (scl_fall) begin
                  if (bit_r < BIT_LAST) begin
                     bit_nxt = bit_r + 1'b1;
                  end else if (bit_r == BIT_LAST) begin
                     bit_nxt = BIT_ACK;
                     oe_nxt  = 1'b1;
                     case (st_r)
                        ST_ADDR: begin
                           if (sh_r[7:1] != SLAVE_ADDR) begin
                              oe_nxt = 1'b0;
                              st_nxt = ST_SKIP;
                           end
                        end
                        ST_CMD:  cmd_nxt = sh_r;
                        ST_DLO:  lo_nxt = sh_r;
                        default: wr_stb = 1'b1;
                     endcase
                  end else begin
                     bit_nxt = '0;
                     oe_nxt  = 1'b0;
                     case (st_r)
                        ST_ADDR: begin
                           if (sh_r[0]) begin
                              // word is captured once, so both bytes agree
                              st_nxt   = ST_TXLO;
                              txd_nxt  = rd_word[7:0];
                              rdhi_nxt = rd_word[15:8];
                              oe_nxt   = ~rd_word[7];
                           end else begin
                              st_nxt = ST_CMD;
                           end
                        end
                        ST_CMD:  st_nxt = ST_DLO;
                        ST_DLO:  st_nxt = ST_DHI;
                        default: st_nxt = ST_SKIP;
                     endcase
                  end
               end
            end
            ST_START: begin
               st_nxt = scl_fall ? ST_ADDR : ST_START;
            end
            ST_TXLO, ST_TXHI: begin
               if (scl_rise && bit_r == BIT_ACK) begin
                  mack_nxt = ~sda_s;
               end
               if (scl_fall) begin
                  if (bit_r < BIT_LAST) begin
                     bit_nxt = bit_r + 1'b1;
                     txd_nxt = {txd_r[6:0], 1'b0};
                     oe_nxt  = ~txd_r[6];
                  end else if (bit_r == BIT_LAST) begin
                     bit_nxt = BIT_ACK;
                     oe_nxt  = 1'b0;
                  end else begin
                     bit_nxt = '0;
                     if (st_r == ST_TXLO && mack_r) begin
                        st_nxt  = ST_TXHI;
                        txd_nxt = rdhi_r;
                        oe_nxt  = ~rdhi_r[7];
                     end else begin
                        st_nxt = ST_SKIP;
                        oe_nxt = 1'b0;
                     end
                  end
               end
            end
            default: begin
               oe_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r    <= ST_IDLE;
         bit_r   <= '0;
         sh_r    <= '0;
         cmd_r   <= '0;
         lo_r    <= '0;
         txd_r   <= '0;
         rdhi_r  <= '0;
         oe_r    <= 1'b0;
         mack_r  <= 1'b0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         st_r    <= st_nxt;
         bit_r   <= bit_nxt;
         sh_r    <= sh_nxt;
         cmd_r   <= cmd_nxt;
         lo_r    <= lo_nxt;
         txd_r   <= txd_nxt;
         rdhi_r  <= rdhi_nxt;
         oe_r    <= oe_nxt;
         mack_r  <= mack_nxt;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // open drain: only ever pulls low, never drives a one
   assign sda_o    = 1'b0;
   assign sda_oe_o = oe_r;

   // ---------------- register storage
   chgrb_word_t regs_nxt [NUM_STORE];
   logic        wr_hit;
   logic        wr_opt_a;
   logic        kick;

   assign wr_hit   = wr_stb & acc_dec[4];
   assign wr_opt_a = wr_hit & (acc_dec[3:0] == IDX_OPT_A);
   assign kick     = wr_hit & (acc_dec[3:0] == IDX_CUR || acc_dec[3:0] == IDX_VOLT);

   always_comb begin
      for (int i = 0; i < NUM_STORE; i++) begin
         regs_nxt[i] = regs_r[i];
         if (wr_hit && acc_dec[3:0] == 4'(i)) begin
            regs_nxt[i] = (regs_r[i] & ~WR_MASK[i]) | (wr_data & WR_MASK[i]);
         end
      end
      regs_nxt[IDX_TSTAT] = throttle_status_i;
      if (wr_opt_a) begin
         if (depleted_s) begin
            regs_nxt[IDX_OPT_A][OPA_BATTERY_MODE_A] = 1'b0;
         end
      end else if (bat_absent_s || depleted_s) begin
         // a host write setting the bit wins this cycle over battery removal; hardware clears next; depletion clears it at once
         regs_nxt[IDX_OPT_A][OPA_BATTERY_MODE_A] = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_STORE; i++) begin
            regs_r[i] <= RST_VAL[i];
         end
      end else begin
         for (int i = 0; i < NUM_STORE; i++) begin
            regs_r[i] <= regs_nxt[i];
         end
      end
   end

   // ---------------- watchdog
   logic wdog_exp;

   chgrb_wdog #(
      .TICK_CYCLES_P (TICK_CYCLES_P)
   ) u_wdog (
      .core_clk_i   (core_clk_i),
      .rst_i        (rst_i),
      .period_sel_i (regs_r[IDX_OPT_A][OPA_WDT_HI:OPA_WDT_LO]),
      .kick_i       (kick),
      .expired_o    (wdog_exp)
   );

   // ---------------- decoded controls
   chgrb_word_t opa;
   chgrb_pwr_t  pwr_r, pwr_nxt;

   assign opa = regs_r[IDX_OPT_A];

   always_comb begin
      opt_o.low_power_select       = opa[OPA_LOWPWR];
      opt_o.watchdog_period_select = opa[OPA_WDT_HI:OPA_WDT_LO];
      opt_o.switching_rate_select  = opa[OPA_FREQ_HI:OPA_FREQ_LO];
      opt_o.battery_mode_a_enable           = opa[OPA_BATTERY_MODE_A];
      opt_o.adapter_monitor_gain   = opa[OPA_ADPGAIN];
      opt_o.discharge_monitor_gain = opa[OPA_DISGAIN];
      opt_o.charge_block           = opa[OPA_BLOCK];
      cfg_o.charge_current_setting  = regs_r[IDX_CUR];
      cfg_o.charge_voltage_setting  = regs_r[IDX_VOLT];
      cfg_o.discharge_current_limit = regs_r[IDX_DIS];
      cfg_o.input_current_limit     = regs_r[IDX_ILIM];
      cfg_o.charge_options_b        = regs_r[IDX_OPT_B];
      cfg_o.charge_options_c        = regs_r[IDX_OPT_C];
      cfg_o.charge_options_d        = regs_r[IDX_OPT_D];
      cfg_o.throttle_options_a      = regs_r[IDX_TOPT_A];
      cfg_o.throttle_options_b      = regs_r[IDX_TOPT_B];
   end

   always_comb begin
      pwr_nxt.converter_enable        = ~wdog_exp;
      pwr_nxt.charge_enable           = ~wdog_exp & ~opa[OPA_BLOCK] & ~opa[OPA_BATTERY_MODE_A]
                                        & (regs_r[IDX_CUR] != '0)
                                        & (regs_r[IDX_VOLT] != '0);
      pwr_nxt.battery_mode_a          = opa[OPA_BATTERY_MODE_A];
      pwr_nxt.adapter_switch_on       = ~opa[OPA_BATTERY_MODE_A];
      pwr_nxt.reverse_block_switch_on = ~opa[OPA_BATTERY_MODE_A];
      pwr_nxt.battery_switch_on       = opa[OPA_BATTERY_MODE_A];
      pwr_nxt.throttle_output_enable  = ~opa[OPA_LOWPWR];
      pwr_nxt.monitor_buffer_enable   = ~opa[OPA_LOWPWR];
      pwr_nxt.comparator_enable       = ~opa[OPA_LOWPWR];
      pwr_nxt.switching_rate_valid    = (opa[OPA_FREQ_HI:OPA_FREQ_LO] != FREQ_RSVD);
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pwr_r <= '0;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   assign pwr_o              = pwr_r;
   assign watchdog_expired_o = wdog_exp;

endmodule // chgrb_bank
`default_nettype wire

// ===== sim/chgrb_bank_chk.sv
`timescale 1ns/10ps
`default_nettype none
module chgrb_bank_chk
   import chgrb_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       scl_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic       battery_present_n_i,
   input wire logic       battery_depleted_i,
   input wire chgrb_opt_t opt_o,
   input wire chgrb_pwr_t pwr_o,
   input wire logic       watchdog_expired_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   AST_OPEN_DRAIN: assert property (sda_oe_o |-> !sda_o)
      else $error("data pin driven high");
   AST_DRIVE_SCL_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
      else $error("data pin taken while bus clock high");
   AST_LOW_POWER: assert property (opt_o.low_power_select |=>
      !pwr_o.throttle_output_enable && !pwr_o.monitor_buffer_enable && !pwr_o.comparator_enable)
      else $error("low power left outputs enabled");
   AST_BATTERY_MODE_A: assert property (opt_o.battery_mode_a_enable |=>
      pwr_o.battery_switch_on && !pwr_o.adapter_switch_on && !pwr_o.reverse_block_switch_on)
      else $error("battery_mode_a mode switches wrong");
   AST_BLOCK: assert property (opt_o.charge_block |=> !pwr_o.charge_enable)
      else $error("charging while blocked");
   AST_WDOG_STOP: assert property (watchdog_expired_o |=> !pwr_o.converter_enable)
      else $error("converter runs after expiry");
   AST_WDOG_OFF: assert property ($rose(watchdog_expired_o) |->
      $past(opt_o.watchdog_period_select) != WDT_OFF)
      else $error("expiry with watchdog off");
   AST_RATE: assert property (!rst_i |=> pwr_o.switching_rate_valid ==
      ($past(opt_o.switching_rate_select) != FREQ_RSVD))
      else $error("switching rate validity wrong");
   AST_BAT_GONE: assert property (battery_present_n_i [*4] |-> ##[0:3] !opt_o.battery_mode_a_enable)
      else $error("battery_mode_a kept with battery absent");
   AST_DEPLETED: assert property (battery_depleted_i [*5] |-> !opt_o.battery_mode_a_enable)
      else $error("battery_mode_a while depleted");
endmodule // chgrb_bank_chk
bind chgrb_bank chgrb_bank_chk i_chgrb_bank_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .battery_present_n_i(battery_present_n_i),
   .battery_depleted_i(battery_depleted_i), .opt_o(opt_o), .pwr_o(pwr_o),
   .watchdog_expired_o(watchdog_expired_o));
`default_nettype wire

// ===== sim/chgrb_host.sv
`timescale 1ns/10ps
`default_nettype none
module chgrb_host
   import chgrb_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic sda_i,
   output var logic  scl_o,
   output var logic  sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic half();
      repeat (5) @(posedge core_clk_i);
   endtask
   // data moves a cycle after the clock fall so the two never race
   task automatic xbit(input logic b, output logic r);
      @(posedge core_clk_i);
      sda_low_o <= !b;
      half();
      scl_o <= 1'b1;
      half();
      r = sda_i;
      scl_o <= 1'b0;
   endtask
   // s high: start or repeated start; s low: stop
   task automatic cond(input logic s);
      @(posedge core_clk_i);
      sda_low_o <= !s;
      half();
      scl_o <= 1'b1;
      half();
      sda_low_o <= s;
      half();
      if (s) scl_o <= 1'b0;
   endtask
   task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ak);
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(last, ak);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] cmd, input chgrb_word_t w,
                     input logic cut, output logic nak);
      logic [7:0] q;
      logic [3:0] a;
      a = 4'h0;
      cond(1'b1);
      xbyte(adr, 1'b1, q, a[0]);
      xbyte(cmd, 1'b1, q, a[1]);
      xbyte(w[7:0], 1'b1, q, a[2]);
      if (!cut) xbyte(w[15:8], 1'b1, q, a[3]);
      cond(1'b0);
      nak = |a;
   endtask
   task automatic rd(input logic [7:0] cmd, output chgrb_word_t w, output logic nak);
      logic [7:0] q;
      logic [3:0] a;
      cond(1'b1);
      xbyte(8'h12, 1'b1, q, a[0]);
      xbyte(cmd, 1'b1, q, a[1]);
      cond(1'b1);
      xbyte(8'h13, 1'b1, q, a[2]);
      xbyte(8'hFF, 1'b0, w[7:0], a[3]);
      xbyte(8'hFF, 1'b1, w[15:8], a[3]);
      cond(1'b0);
      nak = |a[2:0];
   endtask
endmodule // chgrb_host
`default_nettype wire

// ===== sim/chgrb_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module chgrb_bank_tb_top
   import chgrb_pkg::*;
;
   localparam int TICK = 4;
   localparam int WD_CYC = TICK * WDT_SHORT_TICKS;
   localparam logic [7:0] CMDS [14] = '{CMD_OPT_A, CMD_CUR, CMD_VOLT, CMD_OPT_D, CMD_OPT_C,
      CMD_DIS, CMD_TSTAT, CMD_OPT_B, CMD_TOPT_A, CMD_TOPT_B, CMD_ILIM, CMD_MAKER, CMD_PART, 8'h13};
   localparam chgrb_word_t RSTV [14] = '{16'hE108, 16'h0000, 16'h0000, 16'h1A40, 16'h0384,
      16'h1800, 16'h0000, 16'hC210, 16'h4A54, 16'h8120, 16'h1000,
      MAKER_ID_DEF, PART_ID_DEF, 16'h0000};
   localparam chgrb_word_t WRV [14] = '{16'hE339, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'h00C3, 16'hFEFA, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      MAKER_ID_DEF, PART_ID_DEF, 16'h0000};
   logic        core_clk;
   logic        rst;
   logic        bat_n;
   logic        bat_dep;
   logic        scl;
   logic        sda_low;
   logic        sdo;
   logic        oe;
   logic        wdx;
   logic [1:0]  kk;
   logic        nak;
   chgrb_opt_t  opt;
   chgrb_pwr_t  pwr;
   chgrb_word_t fv;
   chgrb_word_t tst = '0;
   chgrb_cfg_t  cfg;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   // pulled-up open-drain line
   wire         sda = !(sda_low || (oe && !sdo));

   chgrb_bank #(.TICK_CYCLES_P(TICK)) i_chgrb_bank (
      .core_clk_i(core_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
      .sda_oe_o(oe), .battery_present_n_i(bat_n), .battery_depleted_i(bat_dep),
      .throttle_status_i(tst), .opt_o(opt), .cfg_o(cfg), .pwr_o(pwr),
      .watchdog_expired_o(wdx));
   chgrb_host i_chgrb_host (.core_clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

   task automatic stop_test();
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input chgrb_word_t e, input chgrb_word_t g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wchk(input logic [7:0] c, input chgrb_word_t w);
      logic k;
      i_chgrb_host.wr(8'h12, c, w, 1'b0, k);
      chk("write ack", 16'h0000, 16'(k));
   endtask
   task automatic rchk(input logic [7:0] c, input chgrb_word_t e);
      chgrb_word_t w;
      logic k;
      i_chgrb_host.rd(c, w, k);
      chk("read ack", 16'h0000, 16'(k));
      chk($sformatf("register %h", c), e, w);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // whole sequence needs about 48k cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      rst = 1'b1;
      bat_n = 1'b0;
      bat_dep = 1'b0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk("option fields", 16'h01D2, 16'(opt));
      foreach (CMDS[i]) rchk(CMDS[i], RSTV[i]);
      tst <= 16'h00C3;
      foreach (CMDS[i]) wchk(CMDS[i], 16'hFFFF);
      foreach (CMDS[i]) rchk(CMDS[i], WRV[i]);
      for (int k = 0; k < 4; k++) begin
         kk = 2'(k);
         fv = {1'b0, kk, 3'h0, kk, 2'h0, 1'b0, kk[0], kk[1], 2'h0, kk[0]};
         wchk(CMD_OPT_A, fv);
         chk("option fields", {8'h00, kk, kk, 1'b0, kk[0], kk[1], kk[0]}, 16'(opt));
      end
      i_chgrb_host.wr(8'h12, CMD_CUR, 16'h1234, 1'b1, nak);
      i_chgrb_host.wr(8'h20, CMD_CUR, 16'h1234, 1'b0, nak);
      chk("foreign address ack", 16'h0001, 16'(nak));
      rchk(CMD_CUR, 16'hFFFF);
      chk("current cfg", 16'hFFFF, cfg.charge_current_setting);
      wchk(CMD_OPT_A, 16'h0020);
      chk("battery_mode_a bit", 16'h0001, 16'(opt.battery_mode_a_enable));
      @(posedge core_clk);
      bat_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      rchk(CMD_OPT_A, 16'h0000);
      @(posedge core_clk);
      bat_n <= 1'b0;
      bat_dep <= 1'b1;
      repeat (8) @(posedge core_clk);
      wchk(CMD_OPT_A, 16'h0020);
      rchk(CMD_OPT_A, 16'h0000);
      @(posedge core_clk);
      bat_dep <= 1'b0;
      wchk(CMD_OPT_A, 16'h2000);
      wchk(CMD_VOLT, 16'h1000);
      repeat (WD_CYC - 600) @(posedge core_clk);
      chk("watchdog early", 16'h0000, 16'(wdx));
      repeat (1200) @(posedge core_clk);
      chk("watchdog expired", 16'h0001, 16'(wdx));
      chk("converter stopped", 16'h0000, 16'(pwr.converter_enable));
      wchk(CMD_CUR, 16'h0100);
      chk("watchdog restarted", 16'h0000, 16'(wdx));
      chk("converter resumed", 16'h0001, 16'(pwr.converter_enable));
      stop_test();
   end
endmodule // chgrb_bank_tb_top
`default_nettype wire
